// file: common/adc_demux_pkg.sv
package adc_demux_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFF_IRQ_MASK = 4'hc;

    // Control register field positions
    localparam int CTRL_SPLIT_BIT = 0;
    localparam int CTRL_RATE_BIT = 1;

    // Status register field positions
    localparam int STAT_DROP_BIT = 0;
    localparam int STAT_PAIR_BIT = 1;
    localparam int STAT_READY_BIT = 2;
    localparam int STAT_MODE_LSB = 3;

    // Interrupt bit positions and width
    localparam int IRQ_W = 2;
    localparam int IRQ_OVER_BIT = 0;
    localparam int IRQ_MODE_BIT = 1;

    // Values after reset
    localparam logic CTRL_SPLIT_RESET = 1'b0;
    localparam logic CTRL_RATE_RESET = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // Conversion code width and special offset-binary codes
    localparam int CODE_W = 8;
    localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
    localparam logic [CODE_W-1:0] CODE_FULL = 8'hff;
    localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
    localparam logic [CODE_W-1:0] CODE_MID_LO = 8'h7f;
    localparam logic [CODE_W-1:0] CODE_MID_HI = 8'h80;

    // Output modes, Gray coded along pass, split, decimate
    typedef enum logic [1:0] {
        PASSTHROUGH_MODE = 2'b00,
        HALFRATE_SPLIT_MODE = 2'b01,
        QUARTER_DECIMATE_MODE = 2'b11
    } mode_e;

    // Mode from the two select bits; rate is ignored while split is off
    function automatic mode_e decode_mode(input logic split, input logic rate);
        if (!split) begin
            return PASSTHROUGH_MODE;
        end
        return rate ? QUARTER_DECIMATE_MODE : HALFRATE_SPLIT_MODE;
    endfunction

endpackage

// file: src/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser for a group of asynchronous pin levels
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1; // First stage, read only by the second

    // Both stages clear on reset, then shift every edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule

`default_nettype wire

// file: src/adc_output_demux.sv
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module adc_output_demux (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Converter side, asynchronous to clk_i
    input wire logic sample_clk_i,
    input wire logic [7:0] code_i,
    input wire logic over_i,
    // Formatted output ports
    output logic [7:0] prim_data_o,
    output logic [7:0] aux_data_o,
    output logic data_ready_clock_o,
    output logic overrange_o,
    // Interrupt
    output logic irq_o
);

    // Synchronised pin group: sampling clock, over flag, code
    logic [9:0] pins_sync;
    logic sclk_s; // Synchronised sampling clock
    logic sclk_d; // Previous synchronised sampling clock
    logic sclk_rise; // Sampling clock rising edge seen
    logic sclk_fall; // Sampling clock falling edge seen
    logic [7:0] code_s; // Synchronised code
    logic over_s; // Synchronised above-full-scale level

    // Conditioned sample
    logic [7:0] samp_code;
    logic samp_over;

    // Control and mode state
    logic ctrl_split; // Split enable bit
    logic ctrl_rate; // Rate select bit
    adc_demux_pkg::mode_e mode_now; // Mode decoded from control
    adc_demux_pkg::mode_e mode_q; // Mode seen last cycle
    logic mode_chg; // Mode changed this cycle
    logic is_pass; // Pass-through mode active
    logic drop_phase; // Quarter mode: high on the sample to drop
    logic pair_phase; // Split modes: high when older word is held
    logic kept; // This edge carries a kept sample
    logic upd; // This edge updates the output ports
    logic [7:0] hold_code; // Older sample of a pair
    logic hold_over; // Overrange of the older sample
    logic next_over; // Flag value for the coming update

    // Bus and interrupt state
    logic bus_req; // Request present and not yet answered
    logic wr_fire; // Write takes effect at this edge
    logic [adc_demux_pkg::IRQ_W-1:0] irq_stat; // Sticky event bits
    logic [adc_demux_pkg::IRQ_W-1:0] irq_mask; // Interrupt enables
    logic [adc_demux_pkg::IRQ_W-1:0] irq_set; // Events this cycle
    logic [adc_demux_pkg::IRQ_W-1:0] irq_clr; // Write-one-to-clear bits
    logic [31:0] rd_mux; // Read data selected by address

    // Pins pass two flip-flops before any logic reads them
    pin_sync #(
        .WIDTH(10)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({sample_clk_i, over_i, code_i}),
        .sync_o(pins_sync)
    );

    assign sclk_s = pins_sync[9];
    assign over_s = pins_sync[8];
    assign code_s = pins_sync[7:0];

    // Edge detector on the synchronised sampling clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;

    // Offset-binary code passes unchanged, clamped at full scale
    assign samp_code = over_s ? adc_demux_pkg::CODE_FULL : code_s;
    // Flag only alongside the all-ones code, so zero code is clear
    assign samp_over = over_s & (samp_code == adc_demux_pkg::CODE_FULL);

    // Mode selection and update qualifiers
    assign mode_now = adc_demux_pkg::decode_mode(ctrl_split, ctrl_rate);
    assign mode_chg = (mode_now != mode_q);
    assign is_pass = (mode_now == adc_demux_pkg::PASSTHROUGH_MODE);
    assign kept = (mode_now != adc_demux_pkg::QUARTER_DECIMATE_MODE) | ~drop_phase;
    assign upd = sclk_rise & ~mode_chg & kept & (is_pass | pair_phase);
    assign next_over = is_pass ? samp_over : (samp_over | hold_over);

    // Mode tracking and sample phases; a mode change restarts them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= adc_demux_pkg::PASSTHROUGH_MODE;
            drop_phase <= 1'b0;
            pair_phase <= 1'b0;
        end else begin
            mode_q <= mode_now;
            if (mode_chg) begin
                drop_phase <= 1'b0;
                pair_phase <= 1'b0;
            end else if (sclk_rise) begin
                drop_phase <= ~drop_phase;
                if (kept && !is_pass) begin
                    pair_phase <= ~pair_phase;
                end
            end
        end
    end

    // Older word of a pair waits here for its partner
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_code <= adc_demux_pkg::CODE_RESET;
            hold_over <= 1'b0;
        end else if (sclk_rise && !mode_chg && kept && !is_pass && !pair_phase) begin
            hold_code <= samp_code;
            hold_over <= samp_over;
        end
    end

    // Output ports load together on each update
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prim_data_o <= adc_demux_pkg::CODE_RESET;
            aux_data_o <= adc_demux_pkg::CODE_RESET;
            overrange_o <= 1'b0;
        end else if (upd) begin
            prim_data_o <= samp_code;
            aux_data_o <= is_pass ? prim_data_o : hold_code;
            overrange_o <= next_over;
        end
    end

    // Data-ready clock: rises with each update, falls half a period on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_ready_clock_o <= 1'b0;
        end else if (mode_chg) begin
            data_ready_clock_o <= 1'b0;
        end else if (upd) begin
            data_ready_clock_o <= 1'b1;
        end else if (sclk_rise && kept && !is_pass) begin
            data_ready_clock_o <= 1'b0;
        end else if (sclk_fall && is_pass) begin
            data_ready_clock_o <= 1'b0;
        end
    end

    // Wishbone request qualifiers; a write lands on the acked edge
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Control register write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_split <= adc_demux_pkg::CTRL_SPLIT_RESET;
            ctrl_rate <= adc_demux_pkg::CTRL_RATE_RESET;
        end else if (wr_fire && wb_adr_i == adc_demux_pkg::OFF_CTRL && wb_sel_i[0]) begin
            ctrl_split <= wb_dat_i[adc_demux_pkg::CTRL_SPLIT_BIT];
            ctrl_rate <= wb_dat_i[adc_demux_pkg::CTRL_RATE_BIT];
        end
    end

    // Interrupt events and their write-one-to-clear strobes
    assign irq_set = {mode_chg, upd & next_over};
    assign irq_clr = (wr_fire && wb_adr_i == adc_demux_pkg::OFF_IRQ_STAT && wb_sel_i[0])
        ? wb_dat_i[adc_demux_pkg::IRQ_W-1:0] : '0;

    // Sticky status: a new event beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= adc_demux_pkg::IRQ_RESET;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    // Interrupt mask register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= adc_demux_pkg::IRQ_RESET;
        end else if (wr_fire && wb_adr_i == adc_demux_pkg::OFF_IRQ_MASK && wb_sel_i[0]) begin
            irq_mask <= wb_dat_i[adc_demux_pkg::IRQ_W-1:0];
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    // Read selection; unmapped offsets read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            adc_demux_pkg::OFF_CTRL: begin
                rd_mux[adc_demux_pkg::CTRL_SPLIT_BIT] = ctrl_split;
                rd_mux[adc_demux_pkg::CTRL_RATE_BIT] = ctrl_rate;
            end
            adc_demux_pkg::OFF_STATUS: begin
                rd_mux[adc_demux_pkg::STAT_DROP_BIT] = drop_phase;
                rd_mux[adc_demux_pkg::STAT_PAIR_BIT] = pair_phase;
                rd_mux[adc_demux_pkg::STAT_READY_BIT] = data_ready_clock_o;
                rd_mux[adc_demux_pkg::STAT_MODE_LSB +: 2] = mode_now;
            end
            adc_demux_pkg::OFF_IRQ_STAT: begin
                rd_mux[adc_demux_pkg::IRQ_W-1:0] = irq_stat;
            end
            adc_demux_pkg::OFF_IRQ_MASK: begin
                rd_mux[adc_demux_pkg::IRQ_W-1:0] = irq_mask;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data captured with the request, valid while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req) begin
            wb_dat_o <= rd_mux;
        end
    end

    // Checks on mode decoding, the formatted output and the bus ack
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Split off selects pass-through on the next cycle
    mode_pass_a: assert property (!ctrl_split |=> mode_q == adc_demux_pkg::PASSTHROUGH_MODE)
        else $error("split off but mode not pass-through");

    // With split on, rate select picks the divided mode
    mode_rate_a: assert property (ctrl_split |=> mode_q == ($past(ctrl_rate) ?
        adc_demux_pkg::QUARTER_DECIMATE_MODE : adc_demux_pkg::HALFRATE_SPLIT_MODE))
        else $error("rate select did not pick the divided mode");

    // Pass-through auxiliary word is the prior primary word
    pass_aux_a: assert property (upd && is_pass |=> aux_data_o == $past(prim_data_o))
        else $error("auxiliary port not one sample behind");

    // Primary port only moves one cycle after a sampling edge
    edge_sample_a: assert property ($changed(prim_data_o) |-> $past(sclk_rise))
        else $error("primary changed without a sampling edge");

    // First sample of a half-rate pair drops the ready clock
    half_fall_a: assert property (sclk_rise && !mode_chg && kept && !is_pass && !pair_phase
        |=> !data_ready_clock_o && $stable(prim_data_o))
        else $error("half-rate ports moved on first sample");

    // Both words change only with a ready rising edge
    ready_rise_a: assert property ($changed(prim_data_o) || $changed(aux_data_o)
        |-> $rose(data_ready_clock_o))
        else $error("data changed without ready rising");

    // Split pair: auxiliary older, primary newer
    split_order_a: assert property (upd && !is_pass |=>
        aux_data_o == $past(hold_code) && prim_data_o == $past(samp_code))
        else $error("split pair order wrong");

    // Dropped quarter-rate sample leaves both words and the ready clock alone
    quarter_drop_a: assert property (sclk_rise && !mode_chg &&
        mode_now == adc_demux_pkg::QUARTER_DECIMATE_MODE && drop_phase
        |=> $stable(prim_data_o) && $stable(aux_data_o) && $stable(data_ready_clock_o))
        else $error("dropped sample reached the ports");

    // Split modes flag a full-scale word on either port
    over_split_a: assert property (upd && !is_pass |=> overrange_o ==
        ($past(samp_over) || $past(hold_over)))
        else $error("split overrange not merged");

    // Pass-through flag follows the primary sample only
    over_pass_a: assert property (upd && is_pass |=> overrange_o == $past(samp_over))
        else $error("pass-through overrange wrong");

    // Above full scale forces the all-ones code
    full_clamp_a: assert property (upd && over_s |=> &prim_data_o)
        else $error("full scale not all-ones");

    // A set flag always sits beside an all-ones word
    over_code_a: assert property (overrange_o |-> prim_data_o == adc_demux_pkg::CODE_FULL ||
        aux_data_o == adc_demux_pkg::CODE_FULL)
        else $error("overrange without all-ones code");

    // Zero code never carries the flag in pass-through
    zero_clear_a: assert property (upd && is_pass && ~|samp_code |=> !overrange_o)
        else $error("zero code flagged overrange");

    // Midscale codes reach the primary port unaltered
    mid_pass_a: assert property (upd && (samp_code == adc_demux_pkg::CODE_MID_LO ||
        samp_code == adc_demux_pkg::CODE_MID_HI) |=> prim_data_o == $past(code_s))
        else $error("midscale code altered");

    // Ack is a single-cycle pulse
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");

endmodule

`default_nettype wire

// file: sim/capture_model.sv
`timescale 1ns/1ns
`default_nettype none

// Downstream receiver: latches both ports and the flag on each ready rise
module capture_model (
    // Clock
    input wire logic clk_i,
    // Formatted ports from the block
    input wire logic data_ready_clock_i,
    input wire logic [7:0] prim_data_i,
    input wire logic [7:0] aux_data_i,
    input wire logic overrange_i,
    // Captured word {flag, older, newer} with its strobe
    output logic cap_valid_o,
    output logic [16:0] cap_word_o
);
    // Ready level seen at the previous edge
    logic ready_q;
    // Rising ready marks a fresh word on both ports
    wire logic ready_rise = data_ready_clock_i & ~ready_q;

    // Capture on ready rise, auxiliary word taken as the earlier one
    always_ff @(posedge clk_i) begin
        ready_q <= data_ready_clock_i;
        cap_valid_o <= ready_rise;
        if (ready_rise) begin
            cap_word_o <= {overrange_i, aux_data_i, prim_data_i};
        end
    end
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
    // Clock, reset and bus drive
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o, irq_o;
    // Converter pins driven by the bench
    logic sample_clk_i, over_i;
    logic [7:0] code_i;
    // Block outputs and captured words
    wire logic [7:0] prim_data_o, aux_data_o;
    wire logic data_ready_clock_o, overrange_o, cap_valid;
    wire logic [16:0] cap_word;
    // Expected results, oldest first
    logic [31:0] exp_bus[$];
    logic [16:0] exp_port[$];
    // Reference model state
    adc_demux_pkg::mode_e mode;
    logic [7:0] last_prim, old_code;
    logic old_over, have_old, keep;
    int error_cnt, samples_checked, seed;

    adc_output_demux adc_output_demux_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sample_clk_i(sample_clk_i), .code_i(code_i), .over_i(over_i),
        .prim_data_o(prim_data_o), .aux_data_o(aux_data_o),
        .data_ready_clock_o(data_ready_clock_o), .overrange_o(overrange_o), .irq_o(irq_o));

    capture_model capture_model_i (.clk_i(clk_i), .data_ready_clock_i(data_ready_clock_o),
        .prim_data_i(prim_data_o), .aux_data_i(aux_data_o), .overrange_i(overrange_o),
        .cap_valid_o(cap_valid), .cap_word_o(cap_word));

    // System clock, 40 ns period
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // Single comparison with report
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Captured port word {flag, older, newer} compare
    task automatic cmp_port(input logic [16:0] got, input logic [16:0] exp);
        cmp32({15'h0, got}, {15'h0, exp});
    endtask

    // Interrupt level compare
    task automatic cmp_irq(input logic got, input logic exp);
        cmp32({31'h0, got}, {31'h0, exp});
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            report_and_stop();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    // Read with its expected word noted first
    task automatic wb_read(input logic [3:0] adr, input logic [31:0] exp);
        exp_bus.push_back(exp);
        wb_xfer(1'b0, adr, 32'h0);
    endtask

    // Interrupt level once the last write has landed
    task automatic chk_irq(input logic exp);
        @(posedge clk_i);
        cmp_irq(irq_o, exp);
    endtask

    // New mode through the control register, status read back
    task automatic set_mode(input logic split, input logic rate, input logic [31:0] stat);
        wb_xfer(1'b1, adr_pkg_ctrl(), {30'h0, rate, split});
        mode = !split ? adc_demux_pkg::PASSTHROUGH_MODE :
            rate ? adc_demux_pkg::QUARTER_DECIMATE_MODE : adc_demux_pkg::HALFRATE_SPLIT_MODE;
        have_old = 1'b0;
        keep = 1'b1;
        wb_read(adr_pkg_ctrl(), {30'h0, rate, split});
        wb_read(adc_demux_pkg::OFF_STATUS, stat);
    endtask

    function automatic logic [3:0] adr_pkg_ctrl();
        return adc_demux_pkg::OFF_CTRL;
    endfunction

    // One sample: note the expected word, then a 320 ns sampling period
    task automatic send(input logic [7:0] c, input logic o);
        logic [7:0] v;
        v = o ? adc_demux_pkg::CODE_FULL : c;
        if (mode == adc_demux_pkg::PASSTHROUGH_MODE) begin
            exp_port.push_back({o, last_prim, v});
            last_prim = v;
        end else if (keep) begin
            if (have_old) exp_port.push_back({o | old_over, old_code, v});
            else {old_code, old_over} = {v, o};
            have_old = ~have_old;
        end
        if (mode == adc_demux_pkg::QUARTER_DECIMATE_MODE) keep = ~keep;
        @(posedge clk_i);
        sample_clk_i <= 1'b0;
        code_i <= c;
        over_i <= o;
        repeat (4) @(posedge clk_i);
        sample_clk_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask

    // Midscale, zero, overranged and midscale codes, then random ones
    task automatic burst(input int n);
        send(adc_demux_pkg::CODE_MID_LO, 1'b0);
        send(adc_demux_pkg::CODE_ZERO, 1'b0);
        send(8'h55, 1'b1);
        send(adc_demux_pkg::CODE_MID_HI, 1'b0);
        for (int i = 4; i < n; i++) begin
            send(8'($random(seed)), ($random(seed) & 3) == 0);
        end
        repeat (8) @(posedge clk_i);
    endtask

    // Results as they appear, checked against the oldest note
    always @(posedge clk_i) begin
        if (wb_cyc_i === 1'b1 && wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            cmp32(wb_dat_o, exp_bus.size() ? exp_bus.pop_front() : ~wb_dat_o);
        end
        if (cap_valid === 1'b1) begin
            cmp_port(cap_word, exp_port.size() ? exp_port.pop_front() : ~cap_word);
        end
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, sample_clk_i, over_i} = 6'b100000;
        {wb_adr_i, wb_sel_i, wb_dat_i, code_i} = {4'h0, 4'hf, 32'h0, 8'h00};
        {error_cnt, samples_checked, seed} = {32'd0, 32'd0, 32'd71014};
        {last_prim, have_old, keep} = {8'h00, 1'b0, 1'b1};
        mode = adc_demux_pkg::PASSTHROUGH_MODE;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_read(adc_demux_pkg::OFF_IRQ_MASK, 32'h0);
        wb_read(4'h2, 32'h0);
        set_mode(1'b0, 1'b1, 32'h00);
        burst(12);
        wb_xfer(1'b1, adc_demux_pkg::OFF_IRQ_STAT, 32'h3);
        wb_read(adc_demux_pkg::OFF_IRQ_STAT, 32'h0);
        set_mode(1'b1, 1'b0, 32'h08);
        wb_read(adc_demux_pkg::OFF_IRQ_STAT, 32'h2);
        chk_irq(1'b0);
        wb_xfer(1'b1, adc_demux_pkg::OFF_IRQ_MASK, 32'h2);
        chk_irq(1'b1);
        wb_xfer(1'b1, adc_demux_pkg::OFF_IRQ_STAT, 32'h2);
        chk_irq(1'b0);
        burst(12);
        chk_irq(1'b0);
        wb_xfer(1'b1, adc_demux_pkg::OFF_IRQ_MASK, 32'h3);
        chk_irq(1'b1);
        wb_xfer(1'b1, adc_demux_pkg::OFF_IRQ_STAT, 32'h1);
        chk_irq(1'b0);
        set_mode(1'b1, 1'b1, 32'h18);
        burst(16);
        cmp32(exp_port.size(), 32'h0);
        cmp32(exp_bus.size(), 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
